// [board_model.sv]
// Board model: pull-up on the watchdog indicator pin and timer enable strap
`timescale 1ns/1ns
module board_model (
    input  wire logic wd_oe_i,
    input  wire logic wd_data_i,
    input  wire logic strap_i,
    output logic      wd_pin_o,
    output logic      enable_pin_o
);
    // Released pin floats up to the pull-up level
    assign wd_pin_o = wd_oe_i ? wd_data_i : 1'b1;
    // Strap to the regulated supply makes the timer usable
    assign enable_pin_o = strap_i;
endmodule // board_model

// [testbench.sv]
// Self-checking bench for the watchdog and discharge timer block
`timescale 1ns/1ns
module testbench;
    import wdog_pkg::*;
    logic        clk_sys_i, reset_i, rd, wr, strap, hot;
    logic        wt, pd, oe, pin, en, slp, ext;
    logic [5:0]  adr;
    logic [31:0] wdat, rdat, q;
    logic [11:0] sw;
    int          error_cnt, checks, cyc;
    localparam logic [31:0] REVISION_WORD = 32'(REVISION_CODE) << ST_REVISION_LSB;

    watchdog_discharge_timer #(.TICK_CYCLES_P(10)) DUT (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
        .discharge_timer_enable_pin_i(en), .over_temperature_i(hot),
        .watchdog_indicator_pin_o(pd), .watchdog_indicator_pin_oe_o(oe),
        .discharge_switch_o(sw), .sleep_o(slp), .extended_balancing_o(ext));
    board_model board (.wd_oe_i(oe), .wd_data_i(pd), .strap_i(strap), .wd_pin_o(pin), .enable_pin_o(en));

    // Clock at 10 MHz
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    // Closing report
    task automatic test_done();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Compare seen against expected
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    // One Avalon access, held until the edge where waitrequest is low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk_sys_i);
        while (wt !== 1'b0) @(posedge clk_sys_i);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // Read a register and compare the masked value
    task automatic rc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(q & m, e);
    endtask
    // Cut a hang short
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 15000) begin
            error_cnt++;
            test_done();
        end
    end
    // Main sequence
    initial begin
        reset_i = 1'b1;
        {rd, wr, strap, hot, adr, wdat, error_cnt, checks} = '0;
        strap = 1'b1;
        repeat (2) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rc(OFS_STATUS_B, 32'h0000_00FF, REVISION_WORD);
        bus(1'b1, OFS_STAGE_LO, 32'h1234_5678);
        bus(1'b1, OFS_STAGE_HI, 32'h0000_1ABC);
        bus(1'b1, OFS_STAGE_PIN, 32'h0000_0055);
        bus(1'b1, OFS_COMMAND, 32'h0000_0007);
        bus(1'b1, OFS_COMMAND, 32'h0000_0009);
        rc(OFS_STATUS_B, 32'h0000_00FF, REVISION_WORD | 32'h0000_0001);
        rc(OFS_STATUS_B, 32'h0000_00FF, REVISION_WORD);
        rc(OFS_CONFIG_LO, '1, 32'h1234_5678);
        rc(OFS_CONFIG_HI, '1, 32'h0000_1ABC);
        rc(OFS_PIN_CTRL, '1, 32'h0000_0055);
        // Just under and just over the watchdog time
        repeat (140) @(negedge clk_sys_i);
        chk(32'(pin), 32'h0000_0000);
        repeat (60) @(negedge clk_sys_i);
        chk(32'(pin), 32'h0000_0001);
        chk(32'(sw), 32'h0000_0ABC);
        chk(32'(ext), 32'h0000_0001);
        rc(OFS_CONFIG_LO, '1, 32'h0000_0000);
        rc(OFS_CONFIG_HI, '1, 32'h0000_1ABC);
        // Just under and just over the half-minute discharge time
        repeat (2600) @(negedge clk_sys_i);
        chk(32'(sw), 32'h0000_0ABC);
        repeat (250) @(negedge clk_sys_i);
        chk(32'(sw), 32'h0000_0000);
        chk(32'(slp), 32'h0000_0001);
        rc(OFS_CONFIG_HI, '1, 32'h0000_0000);
        rc(OFS_PIN_CTRL, '1, 32'h0000_0000);
        // Timer disabled by the strap: watchdog clears everything
        @(posedge clk_sys_i);
        strap <= 1'b0;
        bus(1'b1, OFS_COMMAND, 32'h0000_0007);
        repeat (2) @(negedge clk_sys_i);
        chk(32'(sw), 32'h0000_0ABC);
        repeat (230) @(negedge clk_sys_i);
        chk(32'(sw), 32'h0000_0000);
        rc(OFS_CONFIG_HI, '1, 32'h0000_0000);
        rc(OFS_PIN_CTRL, '1, 32'h0000_0000);
        // Over temperature while discharging
        @(posedge clk_sys_i);
        strap <= 1'b1;
        bus(1'b1, OFS_COMMAND, 32'h0000_0007);
        @(posedge clk_sys_i);
        hot <= 1'b1;
        repeat (3) @(negedge clk_sys_i);
        chk(32'(sw), 32'h0000_0000);
        rc(OFS_CONFIG_LO, '1, 32'h0000_0000);
        @(posedge clk_sys_i);
        hot <= 1'b0;
        rc(OFS_PIN_CTRL, '1, 32'h0000_0055);
        rc(OFS_STATUS_B, 32'h0000_0001, 32'h0000_0001);
        // Two-minute code: band follows the remaining time down
        bus(1'b1, OFS_STAGE_HI, 32'h0000_3ABC);
        bus(1'b1, OFS_COMMAND, 32'h0000_0003);
        rc(OFS_CONFIG_HI, '1, 32'h0000_3ABC);
        repeat (7500) @(negedge clk_sys_i);
        rc(OFS_CONFIG_HI, '1, 32'h0000_2ABC);
        test_done();
    end
endmodule // testbench

// [watchdog_discharge_timer.sv]
// Watchdog, discharge timer and thermal shutdown logic with an Avalon-MM register slave
// Operation
// - Watchdog expires after over two idle seconds
// - Expiry always resets config bytes zero-three
// - Timer disabled: expiry also resets bytes four-five, pins
// - Timer enabled: its expiry resets bytes four-five, pins
// - Expiry releases open-drain watchdog indicator pin
// - Watchdog always on, restarts on checked commands
// - Running timer keeps discharge switches on
// - Timeout code maps to fifteen fixed durations, code zero disables the timer
// - Readback code reports band of remaining time
// - Only config write restarts discharge timer
// - Expiry during config write keeps new data
// - Over temperature resets config, switches off
// - Thermal event sets over-temperature flag
// - Clear-status command sets over-temperature flag
// - Status group B read clears flag
// - Revision and reserved bits always read back
// - Expiry with running timer enters extended balancing
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
module watchdog_discharge_timer #(
    parameter int unsigned TICK_CYCLES_P = wdog_pkg::TICK_CYCLES
) (
    input  wire logic                     clk_sys_i,
    input  wire logic                     reset_i,
    input  wire logic [5:0]               avs_address_i,
    input  wire logic                     avs_read_i,
    input  wire logic                     avs_write_i,
    input  wire logic [31:0]              avs_writedata_i,
    input  wire logic [3:0]               avs_byteenable_i,
    output logic      [31:0]              avs_readdata_o,
    output logic                          avs_waitrequest_o,
    input  wire logic                     discharge_timer_enable_pin_i,
    input  wire logic                     over_temperature_i,
    output logic                          watchdog_indicator_pin_o,
    output logic                          watchdog_indicator_pin_oe_o,
    output logic      [wdog_pkg::DCC_W-1:0] discharge_switch_o,
    output logic                          sleep_o,
    output logic                          extended_balancing_o
);
    import wdog_pkg::*;

    // Duration of a timeout code in half minutes
    function automatic logic [7:0] half_minutes(input logic [3:0] code);
        unique case (code)
            4'h0: half_minutes = 8'h00;
            4'h1: half_minutes = 8'h01;
            4'h2: half_minutes = 8'h02;
            4'h3: half_minutes = 8'h04;
            4'h4: half_minutes = 8'h06;
            4'h5: half_minutes = 8'h08;
            4'h6: half_minutes = 8'h0A;
            4'h7: half_minutes = 8'h14;
            4'h8: half_minutes = 8'h1E;
            4'h9: half_minutes = 8'h28;
            4'hA: half_minutes = 8'h3C;
            4'hB: half_minutes = 8'h50;
            4'hC: half_minutes = 8'h78;
            4'hD: half_minutes = 8'h96;
            4'hE: half_minutes = 8'hB4;
            4'hF: half_minutes = 8'hF0;
        endcase
    endfunction

    // Duration of a timeout code in ticks
    function automatic logic [DT_W-1:0] code_ticks(input logic [3:0] code);
        code_ticks = DT_W'(half_minutes(code)) * TICKS_PER_HALF_MIN;
    endfunction

    // Smallest code whose duration still covers the remaining ticks
    function automatic logic [3:0] band_code(input logic [DT_W-1:0] remaining);
        band_code = 4'h0;
        for (int c = 15; c >= 1; c--) begin
            if (remaining != '0 && remaining <= code_ticks(4'(c))) begin
                band_code = 4'(c);
            end
        end
    endfunction

    // Byte-lane merge of a bus write
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] be);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = be[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
        end
    endfunction

    logic                  ack_q;
    logic [31:0]           readdata_q;
    logic [31:0]           stage_lo_q;
    logic [31:0]           stage_hi_q;
    logic [31:0]           stage_pin_q;
    logic [31:0]           cfg_lo_q;
    logic [CFG_HI_W-1:0]   cfg_hi_q;
    logic [31:0]           pin_ctrl_q;
    logic [PRESCALE_W-1:0] pre_cnt_q;
    logic                  tick_q;
    logic [WD_CNT_W-1:0]   wd_cnt_q;
    logic                  wd_expired_q;
    logic                  wd_drive_q;
    logic [DT_W-1:0]       dt_cnt_q;
    logic                  dt_running_q;
    logic                  over_temperature_flag_q;
    logic                  thermal_prev_q;
    logic [DCC_W-1:0]      switch_q;
    power_state_t          state_q;
    logic [5:0]            word_addr;
    logic                  rd_first;
    logic                  wr_accept;
    logic                  cmd_kick;
    logic                  cfg_commit;
    logic                  pin_commit;
    logic                  clear_status;
    logic                  wd_fire;
    logic                  dt_fire;
    logic                  dt_enabled;
    logic [3:0]            discharge_timeout_code;
    logic [3:0]            stage_code;
    logic [31:0]           status_b;
    logic [31:0]           rd_mux;

    // Bus decode: two cycles per access, reads captured on the first edge
    assign word_addr         = {avs_address_i[5:2], 2'b00};
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
    assign rd_first          = avs_read_i & ~ack_q;
    assign wr_accept         = avs_write_i & ack_q;
    assign avs_readdata_o    = readdata_q;

    // Command decode, only commands with a good check code count
    assign cmd_kick     = wr_accept && word_addr == OFS_COMMAND && avs_writedata_i[CMD_CHECK_OK_BIT];
    assign cfg_commit   = cmd_kick && avs_writedata_i[CMD_WRITE_CONFIG_BIT];
    assign pin_commit   = cmd_kick && avs_writedata_i[CMD_WRITE_PIN_BIT];
    assign clear_status = cmd_kick && avs_writedata_i[CMD_CLEAR_STATUS_BIT];

    // Timer state derived from the live and staged configuration
    assign discharge_timeout_code = cfg_hi_q[TIMEOUT_CODE_LSB +: TIMEOUT_CODE_W];
    assign stage_code             = stage_hi_q[TIMEOUT_CODE_LSB +: TIMEOUT_CODE_W];
    assign dt_enabled = discharge_timer_enable_pin_i && discharge_timeout_code != 4'h0;
    assign wd_fire    = tick_q && !wd_expired_q && !cmd_kick
                        && wd_cnt_q == WD_EXPIRE_TICKS - 5'h1;
    assign dt_fire    = tick_q && dt_running_q && dt_cnt_q == DT_W'(1)
                        && !cfg_commit && discharge_timer_enable_pin_i;

    // Bus handshake
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
        end
    end

    // Status group B word
    always_comb begin
        status_b                                   = '0;
        status_b[ST_OVER_TEMP_BIT]                 = over_temperature_flag_q;
        status_b[ST_RESERVED_LSB +: 2]             = RESERVED_VALUE;
        status_b[ST_REVISION_LSB +: 4]             = REVISION_CODE;
        status_b[ST_WD_EXPIRED_BIT]                = wd_expired_q;
        status_b[ST_POWER_LSB +: 2]                = state_q;
    end

    // Read multiplexer, unmapped offsets read zero
    always_comb begin
        unique case (word_addr)
            OFS_STAGE_LO:  rd_mux = stage_lo_q;
            OFS_STAGE_HI:  rd_mux = stage_hi_q;
            OFS_STAGE_PIN: rd_mux = stage_pin_q;
            OFS_CONFIG_LO: rd_mux = cfg_lo_q;
            OFS_CONFIG_HI: rd_mux = {16'h0000, band_code(dt_cnt_q), cfg_hi_q[DCC_W-1:0]};
            OFS_PIN_CTRL:  rd_mux = pin_ctrl_q;
            OFS_STATUS_B:  rd_mux = status_b;
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data register
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            readdata_q <= 32'h0000_0000;
        end else if (rd_first) begin
            readdata_q <= rd_mux;
        end
    end

    // Staging registers written by software before a commit command
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            stage_lo_q  <= CFG_LO_RESET;
            stage_hi_q  <= 32'(CFG_HI_RESET);
            stage_pin_q <= PIN_CTRL_RESET;
        end else if (wr_accept) begin
            if (word_addr == OFS_STAGE_LO) begin
                stage_lo_q <= merge(stage_lo_q, avs_writedata_i, avs_byteenable_i);
            end
            if (word_addr == OFS_STAGE_HI) begin
                stage_hi_q <= merge(stage_hi_q, avs_writedata_i, avs_byteenable_i) & 32'h0000_FFFF;
            end
            if (word_addr == OFS_STAGE_PIN) begin
                stage_pin_q <= merge(stage_pin_q, avs_writedata_i, avs_byteenable_i);
            end
        end
    end

    // Prescaler giving one tick per time base period
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pre_cnt_q <= '0;
            tick_q    <= 1'b0;
        end else if (pre_cnt_q == PRESCALE_W'(TICK_CYCLES_P - 1)) begin
            pre_cnt_q <= '0;
            tick_q    <= 1'b1;
        end else begin
            pre_cnt_q <= pre_cnt_q + PRESCALE_W'(1);
            tick_q    <= 1'b0;
        end
    end

    // Watchdog counter, cannot be disabled, restarted by every checked command
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            wd_cnt_q     <= '0;
            wd_expired_q <= 1'b0;
            wd_drive_q   <= 1'b1;
        end else if (cmd_kick) begin
            wd_cnt_q     <= '0;
            wd_expired_q <= 1'b0;
            wd_drive_q   <= 1'b1;
        end else if (tick_q && !wd_expired_q) begin
            wd_cnt_q <= wd_cnt_q + WD_CNT_W'(1);
            if (wd_fire) begin
                wd_expired_q <= 1'b1;
                wd_drive_q   <= 1'b0;
            end
        end
    end

    // Open-drain indicator: pulled low while the watchdog runs
    assign watchdog_indicator_pin_o    = 1'b0;
    assign watchdog_indicator_pin_oe_o = wd_drive_q;

    // Discharge timer, loaded only by a configuration commit
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            dt_cnt_q     <= '0;
            dt_running_q <= 1'b0;
        end else if (cfg_commit && !over_temperature_i) begin
            if (discharge_timer_enable_pin_i && stage_code != 4'h0) begin
                dt_cnt_q     <= code_ticks(stage_code);
                dt_running_q <= 1'b1;
            end else begin
                dt_cnt_q     <= '0;
                dt_running_q <= 1'b0;
            end
        end else if (over_temperature_i || !discharge_timer_enable_pin_i) begin
            dt_cnt_q     <= '0;
            dt_running_q <= 1'b0;
        end else if (tick_q && dt_running_q) begin
            dt_cnt_q <= dt_cnt_q - DT_W'(1);
            if (dt_fire) begin
                dt_running_q <= 1'b0;
            end
        end
    end

    // Configuration group: thermal reset first, then a commit, then timer resets
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_lo_q <= CFG_LO_RESET;
            cfg_hi_q <= CFG_HI_RESET;
        end else if (over_temperature_i) begin
            cfg_lo_q <= CFG_LO_RESET;
            cfg_hi_q <= CFG_HI_RESET;
        end else if (cfg_commit) begin
            cfg_lo_q <= stage_lo_q;
            cfg_hi_q <= stage_hi_q[CFG_HI_W-1:0];
        end else begin
            if (wd_fire) begin
                cfg_lo_q <= CFG_LO_RESET;
            end
            if ((wd_fire && !dt_enabled) || dt_fire) begin
                cfg_hi_q <= CFG_HI_RESET;
            end
        end
    end

    // Discharge pin control group, untouched by thermal shutdown
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pin_ctrl_q <= PIN_CTRL_RESET;
        end else if (pin_commit) begin
            pin_ctrl_q <= stage_pin_q;
        end else if ((wd_fire && !dt_enabled) || dt_fire) begin
            pin_ctrl_q <= PIN_CTRL_RESET;
        end
    end

    // Discharge switches follow the cell bits, forced off when too hot
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            switch_q <= '0;
        end else if (over_temperature_i) begin
            switch_q <= '0;
        end else begin
            switch_q <= cfg_hi_q[DCC_W-1:0];
        end
    end
    assign discharge_switch_o = switch_q;

    // Over-temperature flag: a set wins over a read clear in the same cycle
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            thermal_prev_q          <= 1'b0;
            over_temperature_flag_q <= 1'b0;
        end else begin
            thermal_prev_q <= over_temperature_i;
            if ((over_temperature_i && !thermal_prev_q) || clear_status) begin
                over_temperature_flag_q <= 1'b1;
            end else if (rd_first && word_addr == OFS_STATUS_B) begin
                over_temperature_flag_q <= 1'b0;
            end
        end
    end

    // Power state after a watchdog or discharge timer event
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= ST_ACTIVE;
        end else begin
            unique case (state_q)
                ST_ACTIVE: begin
                    if (wd_fire) begin
                        state_q <= dt_enabled ? ST_EXT_BALANCE : ST_SLEEP;
                    end
                end
                ST_EXT_BALANCE: begin
                    if (cmd_kick) begin
                        state_q <= ST_ACTIVE;
                    end else if (dt_fire || !dt_enabled) begin
                        state_q <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (cmd_kick) begin
                        state_q <= ST_ACTIVE;
                    end
                end
                default: state_q <= ST_ACTIVE;
            endcase
        end
    end
    assign sleep_o              = state_q == ST_SLEEP;
    assign extended_balancing_o = state_q == ST_EXT_BALANCE;

    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    AST_WD_EXPIRY_TIME: assert property ($rose(wd_expired_q) |-> $past(tick_q)
        && $past(wd_cnt_q) == WD_EXPIRE_TICKS - 5'h1) else $error("watchdog expired at wrong count");
    AST_WD_RESETS_LOW: assert property (wd_fire && !over_temperature_i |=> cfg_lo_q == CFG_LO_RESET)
        else $error("config bytes zero to three not reset on expiry");
    AST_WD_RESETS_HIGH: assert property (wd_fire && !dt_enabled && !over_temperature_i && !pin_commit
        |=> cfg_hi_q == CFG_HI_RESET && pin_ctrl_q == PIN_CTRL_RESET) else $error("disabled timer case missed reset");
    AST_DT_RESETS_HIGH: assert property (dt_fire && !over_temperature_i && !pin_commit
        |=> cfg_hi_q == CFG_HI_RESET && pin_ctrl_q == PIN_CTRL_RESET) else $error("timer expiry missed reset");
    AST_WD_PIN_RELEASE: assert property (wd_expired_q == !watchdog_indicator_pin_oe_o)
        else $error("indicator pin drive disagrees with watchdog");
    AST_WD_RESTART: assert property (cmd_kick |=> wd_cnt_q == '0 && !wd_expired_q ##1 !wd_expired_q)
        else $error("checked command did not restart watchdog");
    AST_DT_KEEPS_SWITCHES: assert property (wd_fire && dt_enabled && !dt_fire && !over_temperature_i
        |=> cfg_hi_q == $past(cfg_hi_q)) else $error("watchdog cleared running discharge");
    AST_DT_LOAD: assert property (cfg_commit && !over_temperature_i && discharge_timer_enable_pin_i
        && stage_code == 4'h1 |=> dt_cnt_q == TICKS_PER_HALF_MIN && dt_running_q) else $error("bad timer load");
    AST_BAND_ZERO: assert property (dt_running_q == (band_code(dt_cnt_q) != 4'h0))
        else $error("readback band disagrees with timer state");
    AST_DT_NO_RESTART: assert property (cmd_kick && !cfg_commit && dt_running_q && !tick_q
        && discharge_timer_enable_pin_i && !over_temperature_i |=> dt_cnt_q == $past(dt_cnt_q))
        else $error("plain command touched discharge timer");
    AST_COMMIT_WINS: assert property (cfg_commit && !over_temperature_i
        |=> cfg_hi_q == $past(stage_hi_q[CFG_HI_W-1:0])) else $error("new config lost");
    AST_THERMAL_OFF: assert property (over_temperature_i |=> discharge_switch_o == '0
        && cfg_lo_q == CFG_LO_RESET) else $error("thermal shutdown left discharge on");
    AST_OT_SET: assert property ((over_temperature_i && !thermal_prev_q) || clear_status
        |=> over_temperature_flag_q) else $error("over-temperature flag not set");
    AST_OT_CLEAR: assert property (rd_first && word_addr == OFS_STATUS_B && !clear_status
        && !(over_temperature_i && !thermal_prev_q) |=> !over_temperature_flag_q) else $error("flag not cleared");
    AST_EXT_BALANCE: assert property (wd_fire && state_q == ST_ACTIVE && dt_enabled
        |=> extended_balancing_o && !sleep_o) else $error("expiry with timer did not balance");

endmodule // watchdog_discharge_timer

// [wdt_pkg.sv]
// Constants and types for the watchdog and discharge timer block
package wdog_pkg;
    // Clock and time base
    localparam int unsigned CLK_PERIOD_NS      = 100;
    localparam int unsigned TICK_TIME_MS       = 100;
    localparam int unsigned TICK_CYCLES        = TICK_TIME_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int          PRESCALE_W         = 20;
    // Watchdog: expiry needs strictly more than the nominal time
    localparam int unsigned WD_TIME_MS         = 2000;
    localparam int unsigned WD_TICKS           = WD_TIME_MS / TICK_TIME_MS;
    localparam int          WD_CNT_W           = 5;
    localparam logic [4:0]  WD_EXPIRE_TICKS    = 5'(WD_TICKS + 1);
    // Discharge timer counts ticks, table is kept in half minutes
    localparam int unsigned HALF_MIN_MS        = 30000;
    localparam int          DT_W               = 17;
    localparam logic [16:0] TICKS_PER_HALF_MIN = 17'(HALF_MIN_MS / TICK_TIME_MS);
    // Register byte offsets
    localparam logic [5:0]  OFS_STAGE_LO       = 6'h00;
    localparam logic [5:0]  OFS_STAGE_HI       = 6'h04;
    localparam logic [5:0]  OFS_STAGE_PIN      = 6'h08;
    localparam logic [5:0]  OFS_COMMAND        = 6'h0C;
    localparam logic [5:0]  OFS_CONFIG_LO      = 6'h10;
    localparam logic [5:0]  OFS_CONFIG_HI      = 6'h14;
    localparam logic [5:0]  OFS_PIN_CTRL       = 6'h18;
    localparam logic [5:0]  OFS_STATUS_B       = 6'h1C;
    // Command register bits
    localparam int          CMD_CHECK_OK_BIT     = 0;
    localparam int          CMD_WRITE_CONFIG_BIT = 1;
    localparam int          CMD_WRITE_PIN_BIT    = 2;
    localparam int          CMD_CLEAR_STATUS_BIT = 3;
    // Configuration bytes four and five: cell switch bits and timeout code
    localparam int          DCC_W              = 12;
    localparam int          TIMEOUT_CODE_LSB   = 12;
    localparam int          TIMEOUT_CODE_W     = 4;
    localparam int          CFG_HI_W           = 16;
    // Reset values
    localparam logic [31:0] CFG_LO_RESET       = 32'h0000_0000;
    localparam logic [15:0] CFG_HI_RESET       = 16'h0000;
    localparam logic [31:0] PIN_CTRL_RESET     = 32'h0000_0000;
    // Status group B layout
    localparam int          ST_OVER_TEMP_BIT   = 0;
    localparam int          ST_RESERVED_LSB    = 2;
    localparam int          ST_REVISION_LSB    = 4;
    localparam int          ST_WD_EXPIRED_BIT  = 8;
    localparam int          ST_POWER_LSB       = 9;
    localparam logic [3:0]  REVISION_CODE      = 4'h3; // Arbitrary value
    localparam logic [1:0]  RESERVED_VALUE     = 2'h0;
    // Power state of the device core
    typedef enum logic [1:0] {ST_ACTIVE, ST_EXT_BALANCE, ST_SLEEP} power_state_t;
endpackage
